/* src/pcc_pkg.sv */
// Purpose: shared constants for the particle counter control port
// Assumes: 10 MHz core clock
// Notes: times are kept in their own unit, cycle counts derive from them
package pcc_pkg;
   localparam int CLK_MHZ = 10;
   // particle and button pulse width, microseconds
   localparam int PULSE_US = 10;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int PULSE_W = 8;
   // counter clear pulse width, microseconds
   localparam int CLEAR_US = 10;
   localparam int CLEAR_CYC = CLEAR_US * CLK_MHZ;
   // half period of the remote indication flash, milliseconds
   localparam int FLASH_HALF_MS = 250;
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
   localparam int FLASH_W = 22;
   // number of size thresholds: 0.2, 0.3, 0.5, 1, 2 um
   localparam int N_THR = 5;
   localparam int CLASS_W = 3;
   // sample volume selector encodings
   localparam logic [1:0] VOL_MANUAL = 2'h0;
   localparam logic [1:0] VOL_10ML = 2'h1;
   localparam logic [1:0] VOL_100ML = 2'h2;
   // idle level of the connector inputs
   localparam logic PIN_IDLE = 1'h1;
endpackage

/* src/pcc_pulse.sv */
// Purpose: fixed-width one-shot driven from the core clock
// Assumes: trig_i is a one-cycle event on clk_i
// Notes: a trigger while busy restarts the width, so bursts merge
`timescale 1ns/10ps
module pcc_pulse #(
   parameter int CYCLES = 100,
   parameter logic ACTIVE_LVL = 1'h1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // trigger and pulse
   input wire logic trig_i,
   output logic pulse_o
);
   localparam logic [pcc_pkg::PULSE_W-1:0] LOAD =
      pcc_pkg::PULSE_W'(CYCLES - 1);
   localparam logic [pcc_pkg::PULSE_W-1:0] ZERO = '0;

   logic [pcc_pkg::PULSE_W-1:0] cnt;
   logic busy;
   logic [pcc_pkg::PULSE_W-1:0] next_cnt;
   logic next_busy;

   // width counted in clock cycles, not by event rate
   always_comb begin
      next_cnt = cnt;
      next_busy = busy;
      if (trig_i) begin
         next_cnt = LOAD;
         next_busy = 1'h1;
      end else if (busy) begin
         if (cnt == ZERO) begin
            next_busy = 1'h0;
         end else begin
            next_cnt = cnt - 1'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= '0;
         busy <= 1'h0;
         pulse_o <= ~ACTIVE_LVL;
      end else begin
         cnt <= next_cnt;
         busy <= next_busy;
         pulse_o <= next_busy ? ACTIVE_LVL : ~ACTIVE_LVL;
      end
   end

   // cycles the pulse has stood since its last trigger, for the checks
   logic [pcc_pkg::PULSE_W-1:0] held;
   logic [pcc_pkg::PULSE_W-1:0] next_held;

   always_comb begin
      next_held = held;
      if (trig_i) begin
         next_held = ZERO;
      end else if (pulse_o == ACTIVE_LVL) begin
         next_held = held + 1'h1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         held <= '0;
      end else begin
         held <= next_held;
      end
   end

   pulse_width_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      trig_i |=> pulse_o == ACTIVE_LVL && held == ZERO)
      else $error("pulse did not start after trigger");

   pulse_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (pulse_o == ACTIVE_LVL && held < LOAD) |=> pulse_o == ACTIVE_LVL)
      else $error("pulse ended before its width");

   pulse_end_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (pulse_o == ACTIVE_LVL && held == LOAD && !trig_i) |=>
      pulse_o != ACTIVE_LVL)
      else $error("pulse ran past its width");
endmodule

/* src/pcc_port.sv */
// Purpose: control connector logic of a liquid particle counter
// Assumes: panel, detector and serial events are one-cycle pulses on clk_i
// Notes: connector inputs are asynchronous and idle high
// How it works
// - each threshold met pulses high ten microseconds
// - one particle pulses its group and smaller
// - ready follows attached sampler readiness
// - small-volume flag low only for 10 mL
// - auto flag low for 10 or 100 mL
// - window high while counting, clear pulses low
// - laser fault output low while fault lit
// - cell fault output low while fault lit
// - start button press gives low pulse
// - begin input rising edge starts a measurement
// - halt falling edge stops, manual mode only
// - single-shot low forces one-time mode, flashes remote
// - single-shot release restores previous repeat setting
// - remote mode ignores connector inputs and buttons
`timescale 1ns/10ps
module pcc_port #(
   parameter int FLASH_HALF_CYC = pcc_pkg::FLASH_HALF_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // connector inputs, asynchronous, active low
   input wire logic external_begin_in_i,
   input wire logic external_halt_in_i,
   input wire logic external_single_shot_in_i,
   // internal status and events
   input wire logic particle_det_i,
   input wire logic [pcc_pkg::CLASS_W-1:0] particle_class_i,
   input wire logic sampler_attached_i,
   input wire logic sampler_ready_i,
   input wire logic [1:0] volume_sel_i,
   input wire logic repeat_sel_i,
   input wire logic volume_done_i,
   input wire logic laser_fault_indication_i,
   input wire logic cell_fault_indication_i,
   input wire logic start_button_i,
   input wire logic remote_mode_i,
   input wire logic serial_start_i,
   input wire logic serial_stop_i,
   // connector outputs
   output logic [pcc_pkg::N_THR-1:0] size_threshold_pulse_o,
   output logic ready_o,
   output logic small_volume_flag_o,
   output logic auto_volume_flag_o,
   output logic count_window_o,
   output logic clear_n_o,
   output logic laser_fault_out_o,
   output logic cell_fault_out_o,
   output logic button_press_pulse_n_o,
   // mode status
   output logic repeat_mode_o,
   output logic remote_flash_o
);
   typedef enum logic {PCC_IDLE, PCC_RUN} pcc_state_t;

   localparam logic [pcc_pkg::FLASH_W-1:0] FLASH_LOAD =
      pcc_pkg::FLASH_W'(FLASH_HALF_CYC - 1);

   // thresholds met for a size class: class k meets the k lowest
   function automatic logic [pcc_pkg::N_THR-1:0] pcc_thr_mask(
      input logic [pcc_pkg::CLASS_W-1:0] cls);
      logic [pcc_pkg::N_THR-1:0] m;
      m = '0;
      for (int k = 0; k < pcc_pkg::N_THR; k++) begin
         m[k] = (cls > pcc_pkg::CLASS_W'(k));
      end
      return m;
   endfunction

   // synchronisers: s1 feeds s2 only, s3 holds the prior s2 value
   logic [2:0] s1, s2, s3;
   logic [2:0] next_s1, next_s2, next_s3;
   pcc_state_t state, next_state;
   logic saved_repeat, next_saved_repeat;
   logic forced, next_forced;
   logic [pcc_pkg::FLASH_W-1:0] flash_cnt, next_flash_cnt;
   logic flash, next_flash;
   logic ready, small_flag, auto_flag, window, lfault, cfault, rpt;
   logic next_ready, next_small, next_auto, next_window;
   logic next_lfault, next_cfault, next_rpt;
   logic manual, begin_rise, halt_fall, shot_low, start_req, clear_trig;
   logic btn_trig;
   logic [pcc_pkg::N_THR-1:0] thr_trig;

   always_comb begin
      next_s1 = {external_single_shot_in_i, external_halt_in_i,
                 external_begin_in_i};
      next_s2 = s1;
      next_s3 = s2;
   end

   // connector events count only in local mode
   always_comb begin
      manual = (volume_sel_i == pcc_pkg::VOL_MANUAL);
      begin_rise = s2[0] && !s3[0] && !remote_mode_i;
      halt_fall = !s2[1] && s3[1] && manual && !remote_mode_i;
      shot_low = !s2[2] && !remote_mode_i;
      btn_trig = start_button_i && !remote_mode_i;
      start_req = begin_rise || btn_trig || serial_start_i;
   end

   // measurement sequencing; repeat mode restarts after auto volume
   always_comb begin
      next_state = state;
      clear_trig = 1'h0;
      unique case (state)
         PCC_IDLE: begin
            if (start_req) begin
               next_state = PCC_RUN;
               clear_trig = 1'h1;
            end
         end
         PCC_RUN: begin
            if (halt_fall || serial_stop_i) begin
               next_state = PCC_IDLE;
            end else if (volume_done_i && !manual) begin
               if (rpt) begin
                  clear_trig = 1'h1;
               end else begin
                  next_state = PCC_IDLE;
               end
            end
         end
      endcase
   end

   // single-shot override; panel setting is frozen while forced
   always_comb begin
      next_forced = shot_low;
      next_saved_repeat = saved_repeat;
      if (!forced && !shot_low) begin
         next_saved_repeat = repeat_sel_i;
      end
      next_rpt = shot_low ? 1'h0 : next_saved_repeat;
      next_flash_cnt = flash_cnt;
      next_flash = 1'h0;
      if (shot_low) begin
         next_flash = flash;
         if (flash_cnt == '0) begin
            next_flash_cnt = FLASH_LOAD;
            next_flash = !flash;
         end else begin
            next_flash_cnt = flash_cnt - 1'h1;
         end
      end else begin
         next_flash_cnt = FLASH_LOAD;
      end
   end

   always_comb begin
      next_ready = sampler_attached_i && sampler_ready_i;
      next_small = (volume_sel_i != pcc_pkg::VOL_10ML);
      next_auto = manual;
      next_window = (next_state == PCC_RUN);
      next_lfault = !laser_fault_indication_i;
      next_cfault = !cell_fault_indication_i;
      thr_trig = particle_det_i ? pcc_thr_mask(particle_class_i) : '0;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1 <= {3{pcc_pkg::PIN_IDLE}};
         s2 <= {3{pcc_pkg::PIN_IDLE}};
         s3 <= {3{pcc_pkg::PIN_IDLE}};
         state <= PCC_IDLE;
         forced <= 1'h0;
         saved_repeat <= 1'h0;
         flash_cnt <= '0;
         flash <= 1'h0;
         ready <= 1'h0;
         small_flag <= 1'h1;
         auto_flag <= 1'h1;
         window <= 1'h0;
         lfault <= 1'h1;
         cfault <= 1'h1;
         rpt <= 1'h0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
         state <= next_state;
         forced <= next_forced;
         saved_repeat <= next_saved_repeat;
         flash_cnt <= next_flash_cnt;
         flash <= next_flash;
         ready <= next_ready;
         small_flag <= next_small;
         auto_flag <= next_auto;
         window <= next_window;
         lfault <= next_lfault;
         cfault <= next_cfault;
         rpt <= next_rpt;
      end
   end

   assign ready_o = ready;
   assign small_volume_flag_o = small_flag;
   assign auto_volume_flag_o = auto_flag;
   assign count_window_o = window;
   assign laser_fault_out_o = lfault;
   assign cell_fault_out_o = cfault;
   assign repeat_mode_o = rpt;
   assign remote_flash_o = flash;

   for (genvar g = 0; g < pcc_pkg::N_THR; g++) begin : g_thr
      pcc_pulse #(.CYCLES(pcc_pkg::PULSE_CYC), .ACTIVE_LVL(1'h1)) u_thr (
         .clk_i(clk_i),
         .resetn_i(resetn_i),
         .trig_i(thr_trig[g]),
         .pulse_o(size_threshold_pulse_o[g])
      );
   end

   pcc_pulse #(.CYCLES(pcc_pkg::PULSE_CYC), .ACTIVE_LVL(1'h0)) u_btn (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .trig_i(btn_trig),
      .pulse_o(button_press_pulse_n_o)
   );

   pcc_pulse #(.CYCLES(pcc_pkg::CLEAR_CYC), .ACTIVE_LVL(1'h0)) u_clr (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .trig_i(clear_trig),
      .pulse_o(clear_n_o)
   );

   sequence seq_begin_edge;
      !s3[0] && s2[0] && !remote_mode_i && state == PCC_IDLE;
   endsequence
   sequence seq_halt_edge;
      s3[1] && !s2[1] && manual && !remote_mode_i && state == PCC_RUN;
   endsequence

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   thr_cumulative_a: assert property (
      (size_threshold_pulse_o[pcc_pkg::N_THR-1:1] &
       ~size_threshold_pulse_o[pcc_pkg::N_THR-2:0]) == '0)
      else $error("threshold outputs not cumulative");
   thr_start_a: assert property (
      particle_det_i && particle_class_i != '0 |=>
      size_threshold_pulse_o[0] [*8])
      else $error("particle pulse missing");
   ready_follow_a: assert property (
      !sampler_attached_i [*2] |-> !ready_o)
      else $error("ready high without sampler");
   small_flag_a: assert property (
      $stable(volume_sel_i) [*2] |-> small_volume_flag_o ==
      (volume_sel_i != pcc_pkg::VOL_10ML))
      else $error("small volume flag wrong");
   auto_flag_a: assert property (
      $stable(volume_sel_i) [*2] |-> auto_volume_flag_o == manual)
      else $error("auto volume flag wrong");
   window_clear_a: assert property (
      $rose(count_window_o) |-> !clear_n_o)
      else $error("no clear at window start");
   fault_out_a: assert property (
      laser_fault_indication_i && cell_fault_indication_i |=>
      !laser_fault_out_o && !cell_fault_out_o)
      else $error("fault outputs not low");
   button_pulse_a: assert property (
      btn_trig |=> !button_press_pulse_n_o [*8])
      else $error("button pulse missing");
   begin_run_a: assert property (
      seq_begin_edge |=> count_window_o)
      else $error("begin edge did not start");
   halt_stop_a: assert property (
      seq_halt_edge and !serial_stop_i |=> !count_window_o)
      else $error("halt edge did not stop");
   shot_force_a: assert property (
      shot_low |=> !repeat_mode_o)
      else $error("single-shot did not force one-time");
   shot_restore_a: assert property (
      forced && !shot_low |=> repeat_mode_o == $past(saved_repeat))
      else $error("repeat setting not restored");
   remote_ignore_a: assert property (
      remote_mode_i && state == PCC_IDLE && !serial_start_i |=>
      state == PCC_IDLE)
      else $error("remote mode accepted local start");
endmodule

/* verif/pcc_ctrl_model.sv */
// Purpose: outside controller on the rear control connector
// Assumes: the bench calls the tasks; pins idle high
// Notes: every level is held 3 cycles so the sync stages see it
`timescale 1ns/10ps
module pcc_ctrl_model (
   // clock
   input wire logic clk_i,
   // connector pins
   output logic begin_o,
   output logic halt_o,
   output logic single_shot_o
);
   initial begin
      begin_o = 1'h1;
      halt_o = 1'h1;
      single_shot_o = 1'h1;
   end
   // low then back high, rising edge starts
   task automatic start_run();
      @(posedge clk_i) #1 begin_o = 1'h0;
      repeat (3) @(posedge clk_i);
      #1 begin_o = 1'h1;
   endtask
   // falling edge stops, released high again
   task automatic stop_run();
      @(posedge clk_i) #1 halt_o = 1'h0;
      repeat (3) @(posedge clk_i);
      #1 halt_o = 1'h1;
   endtask
   task automatic set_hold(input logic lvl);
      @(posedge clk_i) #1 single_shot_o = lvl;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
endmodule

/* verif/particle_counter_control_port_tb_top.sv */
// Purpose: self-checking bench for the control connector logic
// Assumes: flash half period shortened to 4 cycles
// Notes: a monitor measures pulse widths, button and clear against queued notes, thresholds against PULSE_CYC
`timescale 1ns/10ps
module particle_counter_control_port_tb_top;
   localparam int T = 100;
   logic clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic particle_det_i, sampler_attached_i, sampler_ready_i, repeat_sel_i;
   logic volume_done_i, laser_fault_indication_i, cell_fault_indication_i;
   logic start_button_i, remote_mode_i, serial_start_i, serial_stop_i;
   logic [2:0] particle_class_i;
   logic [1:0] volume_sel_i;
   logic ext_begin, ext_halt, ext_single;
   logic [4:0] thr, last_thr;
   logic ready_o, small_o, auto_o, count_window_o, clear_n_o, laser_o;
   logic cell_o, btn_n, repeat_mode_o, remote_flash_o, f0, seen;
   int n_fail = 0;
   int tests_run = 0;
   int c_thr = 0;
   int c_btn = 0;
   int c_clr = 0;
   int i;
   integer seed = 32'hDBEA4B5B;
   logic [4:0] q_thr[$];
   int q_btn[$];
   int q_clr[$];

   always #(T/2) clk_i = ~clk_i;

   pcc_ctrl_model pcc_ctrl_model_i (.clk_i(clk_i), .begin_o(ext_begin),
      .halt_o(ext_halt), .single_shot_o(ext_single));

   pcc_port #(.FLASH_HALF_CYC(4)) pcc_port_i (.clk_i(clk_i),
      .resetn_i(resetn_i), .external_begin_in_i(ext_begin),
      .external_halt_in_i(ext_halt), .external_single_shot_in_i(ext_single),
      .particle_det_i(particle_det_i), .particle_class_i(particle_class_i),
      .sampler_attached_i(sampler_attached_i),
      .sampler_ready_i(sampler_ready_i), .volume_sel_i(volume_sel_i),
      .repeat_sel_i(repeat_sel_i), .volume_done_i(volume_done_i),
      .laser_fault_indication_i(laser_fault_indication_i),
      .cell_fault_indication_i(cell_fault_indication_i),
      .start_button_i(start_button_i), .remote_mode_i(remote_mode_i),
      .serial_start_i(serial_start_i), .serial_stop_i(serial_stop_i),
      .size_threshold_pulse_o(thr), .ready_o(ready_o),
      .small_volume_flag_o(small_o), .auto_volume_flag_o(auto_o),
      .count_window_o(count_window_o), .clear_n_o(clear_n_o),
      .laser_fault_out_o(laser_o), .cell_fault_out_o(cell_o),
      .button_press_pulse_n_o(btn_n), .repeat_mode_o(repeat_mode_o),
      .remote_flash_o(remote_flash_o));

   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // inputs move 1 ns after the edge, never on it
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // a pulse with no note behind it counts as a mismatch
   always @(negedge clk_i) begin
      if (resetn_i === 1'h1) begin
         if (thr !== 5'h00 && last_thr === 5'h00) begin
            if (q_thr.size() == 0) check("thr extra", 0, 1);
            else check("thr bits", q_thr.pop_front(), thr);
         end
         if (thr !== 5'h00) c_thr++;
         else if (c_thr > 0) begin
            check("thr width", pcc_pkg::PULSE_CYC, c_thr);
            c_thr = 0;
         end
         if (btn_n === 1'h0) c_btn++;
         else if (c_btn > 0) begin
            if (q_btn.size() == 0) check("btn extra", 0, 1);
            else check("btn width", q_btn.pop_front(), c_btn);
            c_btn = 0;
         end
         if (clear_n_o === 1'h0) c_clr++;
         else if (c_clr > 0) begin
            if (q_clr.size() == 0) check("clr extra", 0, 1);
            else check("clr width", q_clr.pop_front(), c_clr);
            c_clr = 0;
         end
      end
      last_thr = thr;
   end

   initial begin
      #(6000 * T);
      n_fail++;
      summarize();
   end

   initial begin
      {particle_det_i, particle_class_i, volume_done_i, repeat_sel_i} = '0;
      {start_button_i, remote_mode_i, serial_start_i, serial_stop_i} = '0;
      {sampler_attached_i, sampler_ready_i, volume_sel_i} = '0;
      {laser_fault_indication_i, cell_fault_indication_i} = '0;
      tick(3);
      resetn_i = 1'h1;
      tick(1);
      check("window rst", 1'h0, count_window_o);
      check("repeat rst", 1'h0, repeat_mode_o);
      for (i = 0; i < 6; i++) begin
         volume_sel_i = 2'(i % 3);
         {sampler_attached_i, sampler_ready_i, laser_fault_indication_i,
            cell_fault_indication_i} = 4'($random(seed));
         tick(2);
         check("small", 32'(volume_sel_i != 2'h1), small_o);
         check("auto", 32'(volume_sel_i == 2'h0), auto_o);
         check("ready", sampler_attached_i & sampler_ready_i,
            ready_o);
         check("laser", !laser_fault_indication_i, laser_o);
         check("cell", !cell_fault_indication_i, cell_o);
      end
      volume_sel_i = 2'h0;
      for (i = 0; i < 6; i++) begin
         particle_det_i = 1'h1;
         particle_class_i = 3'(i);
         if (i > 0) q_thr.push_back(5'((1 << i) - 1));
         tick(1);
         particle_det_i = 1'h0;
         particle_class_i = 3'(($random(seed) & 32'h7FFF) % 6);
         tick(110);
      end
      q_btn.push_back(pcc_pkg::PULSE_CYC);
      q_clr.push_back(pcc_pkg::CLEAR_CYC);
      start_button_i = 1'h1;
      tick(1);
      start_button_i = 1'h0;
      tick(2);
      check("window btn", 1'h1, count_window_o);
      tick(110);
      pcc_ctrl_model_i.stop_run();
      tick(4);
      check("window halt", 1'h0, count_window_o);
      // manual then 10 mL: halt stops manual, is ignored in auto, where volume end stops
      for (i = 0; i < 2; i++) begin
         volume_sel_i = 2'(i);
         q_clr.push_back(pcc_pkg::CLEAR_CYC);
         pcc_ctrl_model_i.start_run();
         tick(8);
         check("window begin", 1'h1, count_window_o);
         tick(110);
         if (i == 1) begin
            pcc_ctrl_model_i.stop_run();
            tick(4);
            check("window auto", 1'h1, count_window_o);
            volume_done_i = 1'h1;
            tick(1);
            volume_done_i = 1'h0;
         end else pcc_ctrl_model_i.stop_run();
         tick(4);
         check("window end", 1'h0, count_window_o);
      end
      volume_sel_i = 2'h0;
      remote_mode_i = 1'h1;
      pcc_ctrl_model_i.start_run();
      start_button_i = 1'h1;
      tick(1);
      start_button_i = 1'h0;
      tick(8);
      check("window remote", 1'h0, count_window_o);
      q_clr.push_back(pcc_pkg::CLEAR_CYC);
      serial_start_i = 1'h1;
      tick(1);
      serial_start_i = 1'h0;
      tick(110);
      check("window serial", 1'h1, count_window_o);
      serial_stop_i = 1'h1;
      tick(1);
      serial_stop_i = 1'h0;
      tick(2);
      check("window sstop", 1'h0, count_window_o);
      remote_mode_i = 1'h0;
      repeat_sel_i = 1'h1;
      tick(2);
      check("repeat on", 1'h1, repeat_mode_o);
      pcc_ctrl_model_i.set_hold(1'h0);
      check("repeat held", 1'h0, repeat_mode_o);
      f0 = remote_flash_o;
      seen = 1'h0;
      for (i = 0; i < 10; i++) begin
         tick(1);
         if (remote_flash_o !== f0) seen = 1'h1;
      end
      check("flash", 1'h1, seen);
      pcc_ctrl_model_i.set_hold(1'h1);
      tick(1);
      check("repeat back", 1'h1, repeat_mode_o);
      check("flash off", 1'h0, remote_flash_o);
      // repeat auto: volume end restarts with a fresh clear
      volume_sel_i = 2'h1;
      q_clr.push_back(pcc_pkg::CLEAR_CYC);
      q_clr.push_back(pcc_pkg::CLEAR_CYC);
      serial_start_i = 1'h1;
      tick(1);
      serial_start_i = 1'h0;
      tick(110);
      volume_done_i = 1'h1;
      tick(1);
      volume_done_i = 1'h0;
      tick(2);
      check("window repeat", 1'h1, count_window_o);
      tick(110);
      serial_stop_i = 1'h1;
      tick(1);
      serial_stop_i = 1'h0;
      tick(2);
      check("window rstop", 1'h0, count_window_o);
      tick(5);
      check("pending", 0, q_thr.size() + q_btn.size() +
         q_clr.size());
      summarize();
   end
endmodule
